// file: hw/wake_event_indicator.sv
// Power management control register, wake cause and power-event pin
//
// Implementation choices: the register addresses and the APB interface to the registers.
`timescale 1ns/1ns
module wake_event_indicator
    import wake_pkg::*;
#(
    parameter int PULSE_LEN = PULSE_CYCLES,
    parameter int SETTLE_LEN = SETTLE_CYCLES
) (
    input wire logic MCLK,
    input wire logic RST,
    input wire wake_pkg::apb_req_t APB_REQ,
    output wake_pkg::apb_rsp_t APB_RSP,
    input wire wake_pkg::wake_events_t WAKE_EVENTS,
    output logic POWER_EVENT_O,
    output logic POWER_EVENT_OE,
    output logic POWER_EVENT_INTERRUPT,
    output logic IRQ
);
    import wake_pkg::*;

    localparam int TW = $clog2(PULSE_LEN + 1);

    logic [1:0] wake_cause_status;
    logic wake_indicate_pulsed;
    logic wake_output_polarity;
    logic wake_output_enable;
    logic push_pull;
    logic energy_detect_enable;
    logic lan_wake_enable;
    power_state_t power_state_select;
    logic ready;
    logic [7:0] settle_count;
    logic [31:0] hardware_configuration_register;
    logic [1:0] int_status;
    logic [1:0] int_mask;
    logic pulse_busy;
    logic static_active;
    logic [1:0] ev_sync;
    logic [1:0] ev_prev;
    logic ev_energy;
    logic ev_frame;
    logic wake_hit;
    logic deactivate;
    logic active;
    logic wr;
    logic rd;
    logic [1:0] cause_clear;
    logic [1:0] next_cause;
    logic [31:0] pmc_read;

    function automatic logic [31:0] reg_read(input logic [7:0] a, input logic [31:0] pmc,
                                             input logic [31:0] cfg, input logic [1:0] st,
                                             input logic [1:0] mk);
        case (a)
            PMC_OFFSET: reg_read = pmc;
            HARDWARE_CONFIGURATION_REGISTER_OFFSET: reg_read = cfg;
            INT_STATUS_OFFSET: reg_read = {30'h0, st};
            INT_MASK_OFFSET: reg_read = {30'h0, mk};
            BYTE_TEST_OFFSET: reg_read = 32'h0;
            default: reg_read = 32'h0;
        endcase
    endfunction

    function automatic logic mapped(input logic [7:0] a);
        mapped = (a == PMC_OFFSET) || (a == HARDWARE_CONFIGURATION_REGISTER_OFFSET) || (a == INT_STATUS_OFFSET) ||
                 (a == INT_MASK_OFFSET) || (a == BYTE_TEST_OFFSET);
    endfunction

    pin_sync #(.WIDTH(2)) u_sync (
        .clk(MCLK),
        .rst(RST),
        .d({WAKE_EVENTS.frame, WAKE_EVENTS.energy}),
        .q(ev_sync)
    );

    always_ff @(posedge MCLK) begin
        if (RST) begin
            ev_prev <= 2'h0;
        end else begin
            ev_prev <= ev_sync;
        end
    end

    // Only enabled sources count as wake events
    assign ev_energy = ev_sync[0] && !ev_prev[0] && energy_detect_enable; // see [R16]
    assign ev_frame = ev_sync[1] && !ev_prev[1] && lan_wake_enable; // see [R16]
    assign wake_hit = ev_energy || ev_frame;

    // Zero-wait APB slave: every access completes in its first access cycle
    assign wr = APB_REQ.psel && APB_REQ.penable && APB_REQ.pwrite;
    assign rd = APB_REQ.psel && APB_REQ.penable && !APB_REQ.pwrite;

    always_ff @(posedge MCLK) begin
        if (RST) begin
            APB_RSP <= '0;
        end else begin
            APB_RSP.pready <= APB_REQ.psel && !APB_REQ.penable;
            APB_RSP.pslverr <= APB_REQ.psel && !APB_REQ.penable && !mapped(APB_REQ.paddr);
            APB_RSP.prdata <= (APB_REQ.psel && !APB_REQ.penable && !APB_REQ.pwrite) ?
                reg_read(APB_REQ.paddr, pmc_read, hardware_configuration_register, int_status, int_mask) : 32'h0;
        end
    end

    logic wr_now;
    assign wr_now = wr && APB_RSP.pready;

    assign pmc_read = {18'h0, power_state_select, 2'b00, lan_wake_enable,
                       energy_detect_enable, 1'b0, push_pull, wake_cause_status,
                       wake_indicate_pulsed, wake_output_polarity, wake_output_enable,
                       ready}; // see [R11]

    always_ff @(posedge MCLK) begin
        if (RST) begin
            wake_indicate_pulsed <= 1'b0;
            wake_output_polarity <= 1'b0;
            wake_output_enable <= 1'b0;
            push_pull <= 1'b0;
            energy_detect_enable <= 1'b0;
            lan_wake_enable <= 1'b0;
        end else if (wr_now && APB_REQ.paddr == PMC_OFFSET && ready) begin
            wake_indicate_pulsed <= APB_REQ.pwdata[PULSED_BIT];
            wake_output_polarity <= APB_REQ.pwdata[POL_BIT];
            wake_output_enable <= APB_REQ.pwdata[OUT_EN_BIT];
            push_pull <= APB_REQ.pwdata[BUF_TYPE_BIT];
            energy_detect_enable <= APB_REQ.pwdata[ENERGY_DETECT_ENABLE_BIT];
            lan_wake_enable <= APB_REQ.pwdata[LAN_EN_BIT];
        end
    end

    always_ff @(posedge MCLK) begin
        if (RST) begin
            hardware_configuration_register <= HARDWARE_CONFIGURATION_REGISTER_RESET;
        end else if (wr_now && APB_REQ.paddr == HARDWARE_CONFIGURATION_REGISTER_OFFSET && ready) begin
            hardware_configuration_register <= APB_REQ.pwdata;
        end
    end

    // Power state; a reduced-power state is left by any byte-test write
    always_ff @(posedge MCLK) begin
        if (RST) begin
            power_state_select <= FULL_POWER_STATE;
        end else if (power_state_select != FULL_POWER_STATE) begin
            if (wr_now && APB_REQ.paddr == BYTE_TEST_OFFSET) begin
                power_state_select <= FULL_POWER_STATE; // see [R15]
            end else if (wake_hit) begin
                power_state_select <= FULL_POWER_STATE;
            end
        end else if (wr_now && APB_REQ.paddr == PMC_OFFSET && ready) begin
            case (APB_REQ.pwdata[STATE_LSB +: 2])
                2'b01: power_state_select <= FRAME_WAKE_STATE; // see [R14]
                2'b10: power_state_select <= ENERGY_DETECT_STATE; // see [R14]
                default: power_state_select <= FULL_POWER_STATE;
            endcase
        end
    end

    // Ready drops on entering reduced power and returns after a settle time
    always_ff @(posedge MCLK) begin
        if (RST) begin
            settle_count <= 8'h00;
            ready <= 1'b0;
        end else if (power_state_select != FULL_POWER_STATE) begin
            settle_count <= 8'h00;
            ready <= 1'b0;
        end else if (!ready) begin
            if (settle_count == 8'(SETTLE_LEN - 1)) begin
                ready <= 1'b1; // see [R11]
            end else begin
                settle_count <= settle_count + 8'h01;
            end
        end
    end

    // Write-one-to-clear, honoured only in full power with ready set
    assign cause_clear = (wr_now && APB_REQ.paddr == PMC_OFFSET && ready &&
                          power_state_select == FULL_POWER_STATE) ?
                         APB_REQ.pwdata[CAUSE_LSB +: 2] : 2'h0; // see [R2] [R3]

    always_comb begin
        next_cause = wake_cause_status & ~cause_clear;
        // A level still present at an enabled source keeps every cause bit, not only its own
        if (ev_sync[0] && energy_detect_enable) begin
            next_cause = next_cause | wake_cause_status; // see [R4]
        end
        if (ev_sync[1] && lan_wake_enable) begin
            next_cause = next_cause | wake_cause_status; // see [R4]
        end
        if (ev_energy && ev_frame) begin
            next_cause = CAUSE_MULTI; // see [R17]
        end else if (ev_energy) begin
            next_cause = (next_cause == CAUSE_NONE || next_cause == CAUSE_ENERGY) ?
                         CAUSE_ENERGY : CAUSE_MULTI; // see [R1] [R17]
        end else if (ev_frame) begin
            next_cause = (next_cause == CAUSE_NONE || next_cause == CAUSE_FRAME) ?
                         CAUSE_FRAME : CAUSE_MULTI; // see [R1] [R17]
        end
    end

    always_ff @(posedge MCLK) begin
        if (RST) begin
            wake_cause_status <= CAUSE_NONE;
        end else begin
            wake_cause_status <= next_cause;
        end
    end

    // Deactivation when the cause is wiped or both event enables are clear
    assign deactivate = (next_cause == CAUSE_NONE && wake_cause_status != CAUSE_NONE) ||
                        (!energy_detect_enable && !lan_wake_enable); // see [R7]

    cycle_timer #(.WIDTH(TW)) u_pulse (
        .clk(MCLK),
        .rst(RST),
        .start(wake_hit && wake_indicate_pulsed),
        .abort(deactivate && !wake_hit),
        .cycles(TW'(PULSE_LEN)),
        .busy(pulse_busy)
    ); // see [R5]

    always_ff @(posedge MCLK) begin
        if (RST) begin
            static_active <= 1'b0;
        end else if (wake_hit && !wake_indicate_pulsed) begin
            static_active <= 1'b1; // see [R6]
        end else if (deactivate || wake_indicate_pulsed) begin
            static_active <= 1'b0; // see [R7]
        end
    end

    assign active = pulse_busy || static_active;

    // Pin drive: open-drain pulls low only while active, push-pull follows polarity
    always_ff @(posedge MCLK) begin
        if (RST) begin
            POWER_EVENT_O <= 1'b0;
            POWER_EVENT_OE <= 1'b0;
        end else if (!wake_output_enable) begin
            POWER_EVENT_O <= 1'b0;
            POWER_EVENT_OE <= 1'b0; // see [R10]
        end else if (!push_pull) begin
            POWER_EVENT_O <= 1'b0;
            POWER_EVENT_OE <= active; // see [R9]
        end else begin
            POWER_EVENT_O <= wake_output_polarity ? active : !active; // see [R8]
            POWER_EVENT_OE <= 1'b1;
        end
    end

    always_ff @(posedge MCLK) begin
        if (RST) begin
            POWER_EVENT_INTERRUPT <= 1'b0;
        end else begin
            POWER_EVENT_INTERRUPT <= active; // see [R10] [R16]
        end
    end

    // Sticky interrupt status: bit0 energy, bit1 frame; set beats clear
    always_ff @(posedge MCLK) begin
        if (RST) begin
            int_status <= 2'h0;
            int_mask <= 2'h0;
        end else begin
            int_status <= (int_status & ~((wr_now && APB_REQ.paddr == INT_STATUS_OFFSET) ?
                          APB_REQ.pwdata[1:0] : 2'h0)) | {ev_frame, ev_energy};
            if (wr_now && APB_REQ.paddr == INT_MASK_OFFSET) begin
                int_mask <= APB_REQ.pwdata[1:0];
            end
        end
    end

    always_ff @(posedge MCLK) begin
        if (RST) begin
            IRQ <= 1'b0;
        end else begin
            IRQ <= |(int_status & int_mask);
        end
    end
endmodule

// file: hw/wake_pkg.sv
// Package with register map, field positions, reset values and carriers
// Notes on behaviour
// [R1] Two-bit wake cause: none, energy, frame, multiple
// [R2] Writing one clears that cause bit only
// [R3] Cause clear works only in full power, ready
// [R4] Cause stays set while any event pending
// [R5] Pulsed mode drives output active for 50 ms
// [R6] Static mode holds output until deactivated
// [R7] Cause clear or enable clear deactivates output
// [R8] Polarity bit selects active high or low
// [R9] Open-drain ignores polarity, always active low
// [R10] Output enable gates pin, not interrupt
// [R11] Ready flag set after stabilising, always readable
// [R12] Host avoids other addresses until ready
// [R13] Host reads only config and power while unready
// [R14] Power state: full, frame wake, energy detect
// [R15] Byte-order test write wakes from reduced power
// [R16] Enabled event raises interrupt, output if enabled
// [R17] Second different event sets cause to multiple
package wake_pkg;
    localparam logic [7:0] PMC_OFFSET = 8'h84;
    localparam logic [7:0] BYTE_TEST_OFFSET = 8'h64;
    localparam logic [7:0] HARDWARE_CONFIGURATION_REGISTER_OFFSET = 8'h74;
    localparam logic [7:0] INT_STATUS_OFFSET = 8'hA0;
    localparam logic [7:0] INT_MASK_OFFSET = 8'hA4;
    localparam int READY_BIT = 0;
    localparam int OUT_EN_BIT = 1;
    localparam int POL_BIT = 2;
    localparam int PULSED_BIT = 3;
    localparam int CAUSE_LSB = 4;
    localparam int BUF_TYPE_BIT = 6;
    localparam int ENERGY_DETECT_ENABLE_BIT = 8;
    localparam int LAN_EN_BIT = 9;
    localparam int STATE_LSB = 12;
    localparam int PULSE_MS = 50;
    localparam int CLK_MHZ = 50;
    localparam int PULSE_CYCLES = PULSE_MS * 1000 * CLK_MHZ;
    localparam int SETTLE_CYCLES = 64;
    localparam logic [31:0] HARDWARE_CONFIGURATION_REGISTER_RESET = 32'h0000_0000;
    localparam logic [1:0] CAUSE_NONE = 2'h0;
    localparam logic [1:0] CAUSE_ENERGY = 2'h1;
    localparam logic [1:0] CAUSE_FRAME = 2'h2;
    localparam logic [1:0] CAUSE_MULTI = 2'h3;
    typedef enum logic [1:0] {
        FULL_POWER_STATE = 2'b00,
        FRAME_WAKE_STATE = 2'b01,
        ENERGY_DETECT_STATE = 2'b10,
        RESERVED_STATE = 2'b11
    } power_state_t;
    typedef struct packed {
        logic [7:0] paddr;
        logic psel;
        logic penable;
        logic pwrite;
        logic [31:0] pwdata;
    } apb_req_t;
    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } apb_rsp_t;
    typedef struct packed {
        logic energy;
        logic frame;
    } wake_events_t;
endpackage

// file: hw/pin_sync.sv
// Two-flop synchroniser for a bus of pin inputs
`timescale 1ns/1ns
module pin_sync #(
    parameter int WIDTH = 2
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta;

    always_ff @(posedge clk) begin
        if (rst) begin
            meta <= '0;
            q <= '0;
        end else begin
            meta <= d;
            q <= meta;
        end
    end
endmodule

// file: hw/cycle_timer.sv
// Down counter that stays busy for a loaded number of cycles
`timescale 1ns/1ns
module cycle_timer #(
    parameter int WIDTH = 22
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic start,
    input wire logic abort,
    input wire logic [WIDTH-1:0] cycles,
    output logic busy
);
    logic [WIDTH-1:0] count;

    always_ff @(posedge clk) begin
        if (rst || abort) begin
            count <= '0;
        end else if (start) begin
            count <= cycles;
        end else if (count != '0) begin
            count <= count - WIDTH'(1);
        end
    end

    assign busy = (count != '0);
endmodule

// file: sim/wake_event_asserts.sv
// Port assertions for the wake event indicator
`timescale 1ns/1ns
module wake_checks
    import wake_pkg::*;
#(
    parameter int PULSE_LEN = 20,
    parameter int SETTLE_LEN = 4
) (
    input wire logic MCLK,
    input wire logic RST,
    input wire wake_pkg::apb_req_t APB_REQ,
    input wire wake_pkg::apb_rsp_t APB_RSP,
    input wire wake_pkg::wake_events_t WAKE_EVENTS,
    input wire logic POWER_EVENT_O,
    input wire logic POWER_EVENT_OE,
    input wire logic POWER_EVENT_INTERRUPT,
    input wire logic IRQ
);
    logic [31:0] cfg;
    logic act;
    logic mapped;
    int run;
    int age;
    int since;
    default clocking @(posedge MCLK); endclocking
    default disable iff (RST);
    // Pin is active when driven at the level the buffer type calls for
    assign act = POWER_EVENT_OE && (cfg[BUF_TYPE_BIT] ? POWER_EVENT_O == cfg[POL_BIT]
        : !POWER_EVENT_O);
    assign mapped = APB_REQ.paddr inside {PMC_OFFSET, BYTE_TEST_OFFSET, HARDWARE_CONFIGURATION_REGISTER_OFFSET,
        INT_STATUS_OFFSET, INT_MASK_OFFSET};
    // Shadow assumes the host writes the control word only while ready
    always_ff @(posedge MCLK) begin
        if (RST) begin
            cfg <= '0;
        end else if (APB_REQ.psel && APB_REQ.penable && APB_RSP.pready && APB_REQ.pwrite
            && APB_REQ.paddr == PMC_OFFSET) begin
            cfg <= APB_REQ.pwdata;
        end
    end
    always_ff @(posedge MCLK) begin
        run <= act ? run + 1 : 0;
        since <= RST ? 0 : (since < 1000 ? since + 1 : since);
        age <= ($rose(WAKE_EVENTS.energy) || $rose(WAKE_EVENTS.frame)) ? 0
            : (age < 100 ? age + 1 : age);
    end
    AST_ANSWER: assert property (APB_REQ.psel && !APB_REQ.penable |=> APB_RSP.pready)
        else $error("no ready in access phase");
    AST_ONE_CYCLE: assert property (APB_RSP.pready |=> !APB_RSP.pready)
        else $error("ready held too long");
    AST_REFUSE: assert property (APB_RSP.pready && !mapped |-> APB_RSP.pslverr
        && APB_RSP.prdata == '0) else $error("unmapped access not refused");
    AST_NOT_READY: assert property (
        APB_RSP.pready && APB_REQ.paddr == PMC_OFFSET && since < SETTLE_LEN
        |-> !APB_RSP.prdata[READY_BIT]) else $error("ready before settling");
    AST_OPEN_DRAIN: assert property (
        POWER_EVENT_OE && !cfg[BUF_TYPE_BIT] && $stable(cfg) && $past(cfg, 2) == cfg
        |-> !POWER_EVENT_O) else $error("open drain driven high");
    AST_GATE: assert property (
        !cfg[OUT_EN_BIT] && $stable(cfg) && $past(cfg, 2) == cfg |-> !POWER_EVENT_OE)
        else $error("pin driven while disabled");
    AST_PULSE: assert property (cfg[PULSED_BIT] |-> run <= PULSE_LEN)
        else $error("pulse too long");
    AST_INT_CAUSE: assert property ($rose(POWER_EVENT_INTERRUPT) |-> age <= 5)
        else $error("interrupt without event");
endmodule
bind wake_event_indicator wake_checks #(.PULSE_LEN(PULSE_LEN), .SETTLE_LEN(SETTLE_LEN))
    chk_u (.MCLK(MCLK), .RST(RST), .APB_REQ(APB_REQ), .APB_RSP(APB_RSP),
    .WAKE_EVENTS(WAKE_EVENTS), .POWER_EVENT_O(POWER_EVENT_O),
    .POWER_EVENT_OE(POWER_EVENT_OE), .POWER_EVENT_INTERRUPT(POWER_EVENT_INTERRUPT),
    .IRQ(IRQ));

// file: sim/host_model.sv
// Host processor model: APB master for the power management registers
`timescale 1ns/1ns
module host_model
    import wake_pkg::*;
(
    input wire logic MCLK,
    input wire wake_pkg::apb_rsp_t APB_RSP,
    output wake_pkg::apb_req_t APB_REQ
);
    int hang = 0;
    initial APB_REQ = '0;
    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d,
        output logic [31:0] q, output logic e);
        int n = 0;
        @(posedge MCLK);
        APB_REQ <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: w, pwdata: d};
        @(posedge MCLK);
        APB_REQ.penable <= 1'b1;
        do begin
            @(posedge MCLK);
            n++;
        end while (APB_RSP.pready !== 1'b1 && n < 50);
        q = APB_RSP.prdata;
        e = APB_RSP.pslverr;
        if (n >= 50) hang++;
        // Released lines carry inverted values, never the last request
        APB_REQ <= '{paddr: ~a, psel: 1'b0, penable: 1'b0, pwrite: ~w, pwdata: ~d};
    endtask
    task automatic wait_ready;
        logic [31:0] q = '0;
        logic e;
        int k = 0;
        while (q[READY_BIT] !== 1'b1 && k < 50) begin
            xfer(PMC_OFFSET, 1'b0, 32'h0, q, e);
            k++;
        end
        if (k >= 50) hang++;
    endtask
endmodule

// file: sim/testbench.sv
// Testbench: host sequences against the wake event indicator
`timescale 1ns/1ns
module testbench;
    import wake_pkg::*;
    localparam int PL = 20;
    logic MCLK;
    logic RST;
    apb_req_t req;
    apb_rsp_t rsp;
    wake_events_t ev;
    logic po;
    logic poe;
    logic pint;
    logic irq;
    logic [31:0] q;
    logic e;
    logic [31:0] c;
    int mismatches = 0;
    int checks_done = 0;
    int n;
    wake_event_indicator #(.PULSE_LEN(PL), .SETTLE_LEN(4)) dut_u (.MCLK(MCLK), .RST(RST),
        .APB_REQ(req), .APB_RSP(rsp), .WAKE_EVENTS(ev), .POWER_EVENT_O(po),
        .POWER_EVENT_OE(poe), .POWER_EVENT_INTERRUPT(pint), .IRQ(irq));
    host_model host_u (.MCLK(MCLK), .APB_RSP(rsp), .APB_REQ(req));
    initial begin
        MCLK = 1'b0;
        forever #10 MCLK = ~MCLK;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        host_u.xfer(a, 1'b1, d, q, e);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        host_u.xfer(a, 1'b0, 32'h0, q, e);
        chk(q, x);
    endtask
    task automatic settle;
        repeat (2) @(posedge MCLK);
        #1;
    endtask
    task automatic fire(input logic [1:0] v);
        @(posedge MCLK);
        ev <= wake_events_t'(v);
        repeat (6) @(posedge MCLK);
        #1;
    endtask
    task automatic pins(input logic [2:0] x);
        chk({29'h0, po, poe, pint}, {29'h0, x});
    endtask
    task automatic results;
        mismatches += host_u.hang;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial begin
        RST = 1'b1;
        ev = '0;
        repeat (8) @(posedge MCLK);
        RST <= 1'b0;
        rd(PMC_OFFSET, 32'h0);
        host_u.wait_ready();
        rd(PMC_OFFSET, 32'h1);
        rd(HARDWARE_CONFIGURATION_REGISTER_OFFSET, HARDWARE_CONFIGURATION_REGISTER_RESET);
        host_u.xfer(8'h10, 1'b0, 32'h0, q, e);
        chk({e, q[30:0]}, 32'h8000_0000);
        $display("test reset done");
        for (int p = 0; p < 2; p++) begin
            c = p ? 32'h0000_0142 : 32'h0000_0146;
            wr(PMC_OFFSET, c);
            fire(2'b10);
            pins({~p[0], 2'b11});
            rd(PMC_OFFSET, c | 32'h11);
            wr(PMC_OFFSET, c | 32'h30);
            rd(PMC_OFFSET, c | 32'h11);
            fire(2'b00);
            wr(PMC_OFFSET, c | 32'h30);
            rd(PMC_OFFSET, c | 32'h01);
            pins({p[0], 2'b10});
        end
        rd(INT_STATUS_OFFSET, 32'h1);
        chk({31'h0, irq}, 32'h0);
        wr(INT_MASK_OFFSET, 32'h1);
        settle;
        chk({31'h0, irq}, 32'h1);
        wr(INT_STATUS_OFFSET, 32'h1);
        settle;
        chk({31'h0, irq}, 32'h0);
        rd(INT_MASK_OFFSET, 32'h1);
        $display("test static done");
        wr(PMC_OFFSET, 32'h0000_0346);
        fire(2'b10);
        fire(2'b11);
        rd(PMC_OFFSET, 32'h0000_0377);
        fire(2'b00);
        wr(PMC_OFFSET, 32'h0000_0046);
        settle;
        pins(3'b010);
        rd(PMC_OFFSET, 32'h0000_0077);
        wr(PMC_OFFSET, 32'h0000_0076);
        rd(PMC_OFFSET, 32'h0000_0047);
        $display("test multiple done");
        wr(PMC_OFFSET, 32'h0000_010E);
        settle;
        fire(2'b00);
        @(posedge MCLK);
        ev <= wake_events_t'(2'b10);
        n = 0;
        while (poe !== 1'b1 && n < 10) begin
            @(posedge MCLK);
            #1;
            n++;
        end
        chk({31'h0, poe}, 32'h1);
        chk({31'h0, po}, 32'h0);
        n = 0;
        while (poe === 1'b1 && n < 100) begin
            @(posedge MCLK);
            #1;
            n++;
        end
        chk(32'(n), 32'(PL));
        fire(2'b00);
        wr(PMC_OFFSET, 32'h0000_013E);
        rd(PMC_OFFSET, 32'h0000_010F);
        wr(PMC_OFFSET, 32'h0000_0144);
        fire(2'b10);
        chk({30'h0, poe, pint}, 32'h1);
        fire(2'b00);
        wr(PMC_OFFSET, 32'h0000_0174);
        $display("test pulse done");
        for (int s = 1; s < 4; s++) begin
            wr(PMC_OFFSET, {18'h0, s[1:0], 12'h000});
            rd(PMC_OFFSET, s == 3 ? 32'h1 : {18'h0, s[1:0], 12'h000});
            wr(BYTE_TEST_OFFSET, 32'h0);
            host_u.wait_ready();
            rd(PMC_OFFSET, 32'h1);
        end
        $display("test power states done");
        results();
    end
endmodule
